// file: logic/ufrt_pkg.sv
// Constants shared by the USB frame timing logic
package ufrt_pkg;

  // ---------------------------------------------------------------------
  // Register bus geometry
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_BIT_TIME_LEFT  = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_FRAME_NUMBER   = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_PERIODIC_START = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_LOW_SPEED_CUT  = 8'h44;

  // ---------------------------------------------------------------------
  // Field widths and positions
  // ---------------------------------------------------------------------
  localparam int unsigned LEFT_W    = 14;  // Bit times left, bits 13:0
  localparam int unsigned FRAME_W   = 16;  // Frame count, bits 15:0
  localparam int unsigned PSTART_W  = 14;  // Periodic start, bits 13:0
  localparam int unsigned LSCUT_W   = 12;  // Low-speed cutoff, bits 11:0
  localparam int unsigned TOGGLE_POS = 31; // Reload toggle flag position

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [LEFT_W-1:0]   LEFT_RST   = 14'h0000;
  localparam logic [FRAME_W-1:0]  FRAME_RST  = 16'h0000;
  localparam logic [PSTART_W-1:0] PSTART_RST = 14'h0000;
  localparam logic [LSCUT_W-1:0]  LSCUT_RST  = 12'h0628;
  localparam logic                TOGGLE_RST = 1'b0;
  localparam logic [DATA_W-1:0]   RDATA_IDLE = 32'h0000_0000;

  // Value that driver software is expected to place in periodic start
  localparam logic [PSTART_W-1:0] PSTART_RECOMMENDED = 14'h3E67;

endpackage : ufrt_pkg

// file: logic/ufrt_bit_counter.sv
// Down counter of bit times left in a frame, reloading at zero
module ufrt_bit_counter
  import ufrt_pkg::*;
#(
  parameter int unsigned W = LEFT_W
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] reload_val_in,
  output logic      [W-1:0] count_out,
  output logic              reload_out
);

  // ---------------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------------
  if (W < 2 || W > LEFT_W) begin : g_bad_width
    $error("ufrt_bit_counter: width out of range");
  end

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] count;
    logic         reload;
  } ufrt_cnt_s;

  ufrt_cnt_s st_r;
  ufrt_cnt_s st_nxt;

  // Decrement per bit time, reload from interval when zero is reached
  always_comb begin
    st_nxt        = st_r;
    st_nxt.reload = 1'b0;
    if (tick_in) begin
      if (st_r.count == '0) begin
        st_nxt.count  = reload_val_in;                   // [R1]
        st_nxt.reload = 1'b1;
      end else begin
        st_nxt.count = st_r.count - W'(1);               // [R2]
      end
    end
  end

  // Reload pulse lines up with the first cycle of the new count
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r.count  <= W'(LEFT_RST);
      st_r.reload <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count_out  = st_r.count;
  assign reload_out = st_r.reload;

endmodule : ufrt_bit_counter

// file: logic/ufrt_frame_timer.sv
// Frame timing registers and counters of a USB host controller
//
// Function
// R1 - At zero, bit-time count reloads from the frame interval value.
// R2 - 14-bit down counter, one decrement per bit time, shows time left.
// R3 - 16-bit frame count increments on each reload; read-only, resets 0.
// R4 - Writable 14-bit periodic start point, reset zero, marks list start.
// R5 - Software should program periodic start with the standard value.
// R6 - Software writes zero to reserved bits and initialises them.
// R7 - Low-speed cutoff compared with time left decides low-speed fit.
// R8 - Reload toggle flag inverts on every reload of the bit counter.
//
// The plain strobed port is this design's own decision.
module ufrt_frame_timer
  import ufrt_pkg::*;
#(
  parameter int unsigned CNT_W   = LEFT_W,
  parameter int unsigned FN_W    = FRAME_W,
  parameter int unsigned PS_W    = PSTART_W,
  parameter int unsigned LS_W    = LSCUT_W
) (
  input  wire logic              REF_CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic              BIT_TICK_IN,
  input  wire logic [CNT_W-1:0]  FRAME_INTERVAL_IN,
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [DATA_W-1:0] WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [DATA_W-1:0] RDATA_OUT,
  output logic      [FN_W-1:0]   FRAME_NUMBER_OUT,
  output logic                   FRAME_START_OUT,
  output logic                   RELOAD_TOGGLE_OUT,
  output logic                   PERIODIC_ACTIVE_OUT,
  output logic                   LS_ALLOWED_OUT
);

  // ---------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------
  // Fields must fit below the toggle bit and the cutoff must not be
  // wider than the counter it is compared against.
  if (CNT_W < 2 || CNT_W > LEFT_W) begin : g_bad_cnt
    $error("ufrt_frame_timer: counter width out of range");
  end
  if (FN_W < 1 || FN_W > FRAME_W) begin : g_bad_fn
    $error("ufrt_frame_timer: frame count width out of range");
  end
  if (PS_W != CNT_W) begin : g_bad_ps
    $error("ufrt_frame_timer: periodic start must match counter width");
  end
  if (LS_W < 1 || LS_W > CNT_W) begin : g_bad_ls
    $error("ufrt_frame_timer: cutoff wider than counter");
  end

  // ---------------------------------------------------------------------
  // State of the module
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [PS_W-1:0]   pstart;      // Periodic start point
    logic [LS_W-1:0]   lscut;       // Low-speed cutoff value
    logic [FN_W-1:0]   frame_cnt;   // Frame count value
    logic              toggle;      // Reload toggle flag
    logic              frame_start; // One cycle per new frame
    logic              periodic;    // Periodic part of the frame
    logic              ls_ok;       // Low-speed packet still fits
    logic [DATA_W-1:0] rdata;       // Read answer
  } ufrt_state_s;

  ufrt_state_s st_r;
  ufrt_state_s st_nxt;

  // ---------------------------------------------------------------------
  // Bit-time counter
  // ---------------------------------------------------------------------
  logic [CNT_W-1:0] bits_left;
  logic             reload_seen;

  // Counter lives in its own module; its outputs are flops already
  ufrt_bit_counter #(
    .W             (CNT_W)
  ) u_bit_counter (
    .clk_in        (REF_CLK_IN),
    .rst_in        (RST_IN),
    .tick_in       (BIT_TICK_IN),
    .reload_val_in (FRAME_INTERVAL_IN),
    .count_out     (bits_left),
    .reload_out    (reload_seen)
  );

  // ---------------------------------------------------------------------
  // Decode of the register bus
  // ---------------------------------------------------------------------
  logic hit_left;
  logic hit_frame;
  logic hit_pstart;
  logic hit_lscut;

  // Full byte address compare; low two bits must be zero
  assign hit_left   = (ADDR_IN == OFS_BIT_TIME_LEFT);
  assign hit_frame  = (ADDR_IN == OFS_FRAME_NUMBER);
  assign hit_pstart = (ADDR_IN == OFS_PERIODIC_START);
  assign hit_lscut  = (ADDR_IN == OFS_LOW_SPEED_CUT);

  // ---------------------------------------------------------------------
  // Read word images
  // ---------------------------------------------------------------------
  logic [DATA_W-1:0] img_left;
  logic [DATA_W-1:0] img_frame;
  logic [DATA_W-1:0] img_pstart;
  logic [DATA_W-1:0] img_lscut;

  // Reserved bits read as zero rather than the undefined stored value
  always_comb begin
    img_left                    = RDATA_IDLE;
    img_left[CNT_W-1:0]         = bits_left;                 // [R2]
    img_left[TOGGLE_POS]        = st_r.toggle;               // [R8]
    img_frame                   = RDATA_IDLE;
    img_frame[FN_W-1:0]         = st_r.frame_cnt;            // [R3]
    img_pstart                  = RDATA_IDLE;
    img_pstart[PS_W-1:0]        = st_r.pstart;               // [R4]
    img_lscut                   = RDATA_IDLE;
    img_lscut[LS_W-1:0]         = st_r.lscut;
  end

  // ---------------------------------------------------------------------
  // Comparisons against the bit-time count
  // ---------------------------------------------------------------------
  logic [CNT_W-1:0] lscut_wide;
  logic             in_periodic;
  logic             ls_fits;

  // Cutoff is zero-extended to the counter width before comparing
  assign lscut_wide  = CNT_W'(st_r.lscut);
  assign in_periodic = (bits_left <= st_r.pstart);           // [R4]
  assign ls_fits     = (bits_left > lscut_wide);             // [R7]

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  // Writes to the counter and frame count words are dropped: both are
  // owned by hardware. Bits above a field are discarded on write, so a
  // careless non-zero reserved write cannot disturb the counters.
  always_comb begin
    st_nxt             = st_r;
    st_nxt.frame_start = 1'b0;
    st_nxt.rdata       = RDATA_IDLE;

    // New frame bookkeeping follows the counter reload
    if (reload_seen) begin
      st_nxt.frame_cnt   = st_r.frame_cnt + FN_W'(1);        // [R3]
      st_nxt.toggle      = ~st_r.toggle;                     // [R8]
      st_nxt.frame_start = 1'b1;
    end

    // Software writes to the two writable words
    if (WR_IN) begin
      if (hit_pstart) begin
        st_nxt.pstart = WDATA_IN[PS_W-1:0];                  // [R4]
      end
      if (hit_lscut) begin
        st_nxt.lscut = WDATA_IN[LS_W-1:0];                   // [R7]
      end
    end

    // Read answer lands in the following cycle only
    if (RD_IN) begin
      if (hit_left) begin
        st_nxt.rdata = img_left;
      end else if (hit_frame) begin
        st_nxt.rdata = img_frame;
      end else if (hit_pstart) begin
        st_nxt.rdata = img_pstart;
      end else if (hit_lscut) begin
        st_nxt.rdata = img_lscut;
      end else begin
        st_nxt.rdata = RDATA_IDLE;                // Unmapped reads zero
      end
    end

    // Status levels track the counter one cycle behind
    st_nxt.periodic = in_periodic;
    st_nxt.ls_ok    = ls_fits;
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      st_r.pstart      <= PS_W'(PSTART_RST);
      st_r.lscut       <= LS_W'(LSCUT_RST);
      st_r.frame_cnt   <= FN_W'(FRAME_RST);
      st_r.toggle      <= TOGGLE_RST;
      st_r.frame_start <= 1'b0;
      st_r.periodic    <= 1'b0;
      st_r.ls_ok       <= 1'b0;
      st_r.rdata       <= RDATA_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs, all taken straight from flops
  // ---------------------------------------------------------------------
  assign RDATA_OUT           = st_r.rdata;
  assign FRAME_NUMBER_OUT    = st_r.frame_cnt;
  assign FRAME_START_OUT     = st_r.frame_start;
  assign RELOAD_TOGGLE_OUT   = st_r.toggle;
  assign PERIODIC_ACTIVE_OUT = st_r.periodic;
  assign LS_ALLOWED_OUT      = st_r.ls_ok;

endmodule : ufrt_frame_timer

// file: bench/ufrt_frame_timer_assertions.sv
// Port-level checker of the frame timing block
module ufrt_frame_timer_assertions
  import ufrt_pkg::*;
#(
  parameter int unsigned FN_W = FRAME_W
) (
  input wire logic              REF_CLK_IN,
  input wire logic              RST_IN,
  input wire logic              WR_IN,
  input wire logic              RD_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [DATA_W-1:0] RDATA_OUT,
  input wire logic [FN_W-1:0]   FRAME_NUMBER_OUT,
  input wire logic              FRAME_START_OUT,
  input wire logic              RELOAD_TOGGLE_OUT,
  input wire logic              PERIODIC_ACTIVE_OUT,
  input wire logic              LS_ALLOWED_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);

  // Reload bookkeeping: count and toggle move only with the pulse
  property p_fn_step;
    FRAME_START_OUT |-> FRAME_NUMBER_OUT == $past(FRAME_NUMBER_OUT) + 1'b1;
  endproperty
  a_fn_step: assert property (p_fn_step)
    else $error("frame count did not step on frame start");
  property p_fn_hold;
    !$past(RST_IN) && $changed(FRAME_NUMBER_OUT) |-> FRAME_START_OUT;
  endproperty
  a_fn_hold: assert property (p_fn_hold)
    else $error("frame count moved without frame start");
  property p_toggle;
    !$past(RST_IN) |-> FRAME_START_OUT == $changed(RELOAD_TOGGLE_OUT);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle flag out of step with reloads");
  // Counter only jumps up at a reload; a write exactly two cycles earlier is excused
  property p_ls_rise;
    $rose(LS_ALLOWED_OUT) |-> FRAME_START_OUT || $past(WR_IN, 2);
  endproperty
  a_ls_rise: assert property (p_ls_rise)
    else $error("low-speed fit rose outside a reload");
  property p_ps_fall;
    $fell(PERIODIC_ACTIVE_OUT) |-> FRAME_START_OUT || $past(WR_IN, 2);
  endproperty
  a_ps_fall: assert property (p_ps_fall)
    else $error("periodic window ended outside a reload");
  property p_fn_read;
    RD_IN && ADDR_IN == OFS_FRAME_NUMBER |=>
      RDATA_OUT == 32'($past(FRAME_NUMBER_OUT));
  endproperty
  a_fn_read: assert property (p_fn_read)
    else $error("frame count read differs from frame count");
endmodule : ufrt_frame_timer_assertions

bind ufrt_frame_timer ufrt_frame_timer_assertions #(.FN_W(FN_W)) i_chk (
  .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .ADDR_IN(ADDR_IN), .RDATA_OUT(RDATA_OUT),
  .FRAME_NUMBER_OUT(FRAME_NUMBER_OUT), .FRAME_START_OUT(FRAME_START_OUT),
  .RELOAD_TOGGLE_OUT(RELOAD_TOGGLE_OUT),
  .PERIODIC_ACTIVE_OUT(PERIODIC_ACTIVE_OUT), .LS_ALLOWED_OUT(LS_ALLOWED_OUT));

// file: bench/ufrt_bit_source.sv
// Bus-side bit-time source: bursts of ticks with a chosen gap
module ufrt_bit_source (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        go_in,
  input  wire logic [15:0] count_in,
  input  wire logic [3:0]  gap_in,
  output logic             tick_out,
  output logic             busy_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] left_r;
  logic [3:0]  wait_r;

  // Tick stays low outside a burst, so no stray bit times
  always_ff @(posedge clk_in) begin
    tick_out <= 1'b0;
    if (rst_in) begin
      left_r <= 16'h0000;
      wait_r <= 4'h0;
    end else if (go_in) begin
      left_r <= count_in;
      wait_r <= 4'h0;
    end else if (left_r != 16'h0000) begin
      if (wait_r == 4'h0) begin
        tick_out <= 1'b1;
        left_r   <= left_r - 16'h0001;
        wait_r   <= gap_in;
      end else begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
  assign busy_out = go_in || (left_r != 16'h0000);
endmodule : ufrt_bit_source

// file: bench/testbench.sv
// Self-checking bench for the frame timing block
module testbench
  import ufrt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PS = 7;
  localparam int LS = 4;
  logic               clk, rst, go, wr, rd, tick, busy;
  logic               fstart, tgl, pact, lsok;
  logic [15:0]        n_ticks;
  logic [3:0]         gap;
  logic [LEFT_W-1:0]  frame_interval_value;
  logic [ADDR_W-1:0]  addr;
  logic [DATA_W-1:0]  wdata, rdata;
  logic [FRAME_W-1:0] fnum;
  int                 mismatches, n_tests, cnt, reloads;
  // Burst table: ticks, gap, interval; crosses reloads and interval changes
  int tbl [5][3] = '{'{1, 0, 10}, '{5, 2, 10}, '{6, 0, 20}, '{21, 1, 20},
                     '{30, 0, 3}};

  ufrt_frame_timer i_dut (
    .REF_CLK_IN(clk), .RST_IN(rst), .BIT_TICK_IN(tick),
    .FRAME_INTERVAL_IN(frame_interval_value), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .FRAME_NUMBER_OUT(fnum),
    .FRAME_START_OUT(fstart), .RELOAD_TOGGLE_OUT(tgl),
    .PERIODIC_ACTIVE_OUT(pact), .LS_ALLOWED_OUT(lsok));
  ufrt_bit_source i_src (.clk_in(clk), .rst_in(rst), .go_in(go),
    .count_in(n_ticks), .gap_in(gap), .tick_out(tick), .busy_out(busy));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Strobes drop with a cycle between accesses to avoid double drives
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
    @(posedge clk);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    #1;
    chk(nm, rdata, e);
    @(posedge clk);
  endtask : reg_rd

  task automatic do_reset;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cnt     = 0;
    reloads = 0;
    reg_rd(OFS_BIT_TIME_LEFT, 32'h0000_0000, "left");
    reg_rd(OFS_FRAME_NUMBER, 32'h0000_0000, "frame");
    reg_rd(OFS_PERIODIC_START, 32'h0000_0000, "pstart");
    reg_rd(OFS_LOW_SPEED_CUT, 32'h0000_0628, "cutoff");
    reg_rd(8'h48, 32'h0000_0000, "unmapped");
    $display("reset test done");
  endtask : do_reset

  // Reference count runs ahead of the burst; reload takes the interval
  task automatic run_ticks(input int n, g, iv);
    int i;
    frame_interval_value     <= iv[13:0];
    n_ticks <= n[15:0];
    gap     <= g[3:0];
    go      <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < n; i++) begin
      if (cnt == 0) begin
        cnt = iv;
        reloads++;
      end else begin
        cnt--;
      end
    end
    for (i = 0; i < 2000 && busy; i++) @(posedge clk);
    if (busy) begin
      mismatches++;
      results();
    end
    repeat (3) @(posedge clk);
    chk("periodic", 32'(pact), 32'(cnt <= PS));
    chk("lowspeed", 32'(lsok), 32'(cnt > LS));
    chk("fnum", 32'(fnum), 32'(reloads[15:0]));
    chk("toggle", 32'(tgl), 32'(reloads[0]));
    reg_rd(OFS_BIT_TIME_LEFT, {reloads[0], 17'h0_0000, cnt[13:0]},
           "left");
    reg_rd(OFS_FRAME_NUMBER, {16'h0000, reloads[15:0]}, "frame");
  endtask : run_ticks

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // Reset, register access, frame bursts, reset again after the last burst
  initial begin
    {go, wr, rd, n_ticks, gap, frame_interval_value, addr, wdata} = '0;
    rst        = 1'b1;
    mismatches = 0;
    n_tests    = 0;
    do_reset();
    reg_wr(OFS_PERIODIC_START, 32'hFFFF_FFFF);
    reg_rd(OFS_PERIODIC_START, 32'h0000_3FFF, "pstart");
    reg_wr(OFS_LOW_SPEED_CUT, 32'hFFFF_FFFF);
    reg_rd(OFS_LOW_SPEED_CUT, 32'h0000_0FFF, "cutoff");
    reg_wr(OFS_FRAME_NUMBER, 32'hFFFF_FFFF);
    reg_rd(OFS_FRAME_NUMBER, 32'h0000_0000, "frame");
    reg_wr(OFS_BIT_TIME_LEFT, 32'hFFFF_FFFF);
    reg_rd(OFS_BIT_TIME_LEFT, 32'h0000_0000, "left");
    reg_wr(OFS_PERIODIC_START, {18'h0_0000, PSTART_RECOMMENDED});
    reg_rd(OFS_PERIODIC_START, 32'h0000_3E67, "pstart");
    reg_wr(OFS_PERIODIC_START, 32'h0000_0007);
    reg_wr(OFS_LOW_SPEED_CUT, 32'h0000_0004);
    $display("register test done");
    foreach (tbl[k]) run_ticks(tbl[k][0], tbl[k][1], tbl[k][2]);
    $display("frame test done");
    do_reset();
    results();
  end
endmodule : testbench
